//--- hw/drive_status_pkg.sv
// Purpose: Shared constants for the drive status word bank.
// Assumes: One 100 MHz clock, all status sources on that clock.
// Notes:   Bit positions, read indices and speed scaling live here.
package drive_status_pkg;

  // --------------------------------------------------------------
  // Word widths and read indices
  // --------------------------------------------------------------
  localparam int          WORD_W          = 16;
  localparam int          IDX_W           = 10;
  localparam logic [9:0]  IDX_PRIMARY     = 10'h2a8;  // 680
  localparam logic [9:0]  IDX_SPEED       = 10'h2a9;  // 681
  localparam logic [9:0]  IDX_SECONDARY   = 10'h2b2;  // 690
  localparam logic [15:0] STATUS_RST      = 16'h0000;
  localparam logic [15:0] SPEED_RST       = 16'h0000;

  // --------------------------------------------------------------
  // Primary status word bit positions
  // --------------------------------------------------------------
  localparam int          PB_RUN_CMD      = 1;
  localparam int          PB_FIRE_MODE    = 2;
  localparam int          PB_SECOND_RAMP  = 5;
  localparam int          PB_CONFIG       = 6;
  localparam int          PB_ALARM        = 7;
  localparam int          PB_RUNNING      = 8;
  localparam int          PB_ENABLED      = 9;
  localparam int          PB_FORWARD      = 10;
  localparam int          PB_JOG          = 11;
  localparam int          PB_REMOTE       = 12;
  localparam int          PB_UNDERVOLT    = 13;
  localparam int          PB_FAULT        = 15;
  localparam logic [15:0] PRI_RSV_MASK    = 16'h4019;  // bits 0, 3, 4, 14

  // --------------------------------------------------------------
  // Secondary status word bit positions
  // --------------------------------------------------------------
  localparam int          SB_DC_EXT       = 2;
  localparam int          SB_ENERGY_SAVE  = 3;
  localparam int          SB_FREQ_REDUCE  = 4;
  localparam int          SB_DECEL        = 6;
  localparam int          SB_ACCEL        = 7;
  localparam int          SB_FROZEN       = 8;
  localparam int          SB_SETPOINT_OK  = 9;
  localparam int          SB_DC_REG       = 10;
  localparam int          SB_CFG_50HZ     = 11;
  localparam int          SB_RIDE_THRU    = 12;
  localparam int          SB_FLYING       = 13;
  localparam int          SB_DC_BRAKE     = 14;
  localparam int          SB_PWM_ON       = 15;
  localparam logic [15:0] SEC_RSV_MASK    = 16'h0023;  // bits 0, 1, 5

  // --------------------------------------------------------------
  // Speed scaling
  // --------------------------------------------------------------
  localparam int          SCALE_SHIFT     = 13;         // rated = 2**13
  localparam logic [15:0] SPEED_RATED     = 16'h2000;   // 8192
  localparam logic [15:0] SPEED_POS_MAX   = 16'h7fff;   // 32767
  localparam logic [15:0] SPEED_NEG_MAX   = 16'h8000;   // -32768
  localparam int          NUM_W           = 29;         // 16 + 13
  localparam logic [4:0]  DIV_LAST_STEP   = 5'h1c;      // 29 steps

  typedef enum logic [1:0] {
    DIV_IDLE,
    DIV_RUN,
    DIV_DONE
  } div_state_t;

endpackage : drive_status_pkg

//--- hw/speed_scaler.sv
// Purpose: Scales the output frequency to the signed 16-bit speed word.
// Assumes: Frequency and rated frequency share one unit.
// Notes:   Sequential divider, one result every 32 cycles.
module speed_scaler
  import drive_status_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst_b,
  input  wire logic                  start,
  input  wire logic signed [15:0]    freq_in,
  input  wire logic        [15:0]    rated_in,
  output logic             [15:0]    speed_ff,
  output logic                       done_ff
);
  import drive_status_pkg::*;

  div_state_t        state_ff;
  logic [NUM_W-1:0]  num_ff;
  logic [NUM_W-1:0]  quot_ff;
  logic [16:0]       rem_ff;
  logic [15:0]       div_ff;
  logic              neg_ff;
  logic [4:0]        cnt_ff;
  logic [16:0]       trial;
  logic              fits;
  logic [15:0]       mag_in;

  // Magnitude; -32768 maps to 16'h8000 unsigned
  assign mag_in = freq_in[15] ? 16'(-freq_in) : freq_in;
  assign trial  = {rem_ff[15:0], num_ff[NUM_W-1]};
  assign fits   = trial >= {1'b0, div_ff};

  // ------------------------------------------------------------
  // Restoring divider: quot = |freq| * 8192 / rated
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= DIV_IDLE;
      num_ff   <= '0;
      quot_ff  <= '0;
      rem_ff   <= '0;
      div_ff   <= '0;
      neg_ff   <= 1'b0;
      cnt_ff   <= '0;
    end else begin
      case (state_ff)
        DIV_IDLE: begin
          if (start) begin
            num_ff   <= {mag_in, 13'h0000};
            div_ff   <= rated_in;
            neg_ff   <= freq_in[15];
            quot_ff  <= '0;
            rem_ff   <= '0;
            cnt_ff   <= '0;
            state_ff <= DIV_RUN;
          end
        end
        DIV_RUN: begin
          rem_ff  <= fits ? (trial - {1'b0, div_ff}) : trial;
          quot_ff <= {quot_ff[NUM_W-2:0], fits};
          num_ff  <= {num_ff[NUM_W-2:0], 1'b0};
          cnt_ff  <= cnt_ff + 5'h01;
          if (cnt_ff == DIV_LAST_STEP) begin
            state_ff <= DIV_DONE;
          end
        end
        DIV_DONE: state_ff <= DIV_IDLE;
        default:  state_ff <= DIV_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Signed result with clamp to the 16-bit range
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      speed_ff <= SPEED_RST;
      done_ff  <= 1'b0;
    end else begin
      done_ff <= (state_ff == DIV_DONE);
      if (state_ff == DIV_DONE) begin
        // Zero rated frequency clamps rather than dividing by zero
        if (!neg_ff) begin
          if (div_ff == 16'h0000 || quot_ff > NUM_W'(SPEED_POS_MAX)) begin
            speed_ff <= SPEED_POS_MAX;
          end else begin
            speed_ff <= quot_ff[15:0];
          end
        end else begin
          if (div_ff == 16'h0000 || quot_ff > NUM_W'(SPEED_NEG_MAX)) begin
            speed_ff <= SPEED_NEG_MAX;
          end else begin
            speed_ff <= 16'(-quot_ff[15:0]);
          end
        end
      end
    end
  end

endmodule : speed_scaler

//--- hw/drive_status_word_bank.sv
// Purpose: Read-only status words of the drive and its scaled speed.
// Assumes: All condition inputs come from logic on ref_clk.
// Notes:   Reads by index answer one cycle later; writes are refused.
module drive_status_word_bank
  import drive_status_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst_b,
  // Drive conditions
  input  wire logic                  run_cmd,
  input  wire logic                  fire_mode_act,
  input  wire logic                  second_ramp_sel,
  input  wire logic                  config_state,
  input  wire logic                  alarm_act,
  input  wire logic                  motor_running,
  input  wire logic                  drive_enabled,
  input  wire logic                  dir_forward,
  input  wire logic                  jog_act,
  input  wire logic                  remote_mode,
  input  wire logic                  undervoltage,
  input  wire logic                  fault_act,
  input  wire logic                  dc_ext_act,
  input  wire logic                  energy_save_act,
  input  wire logic                  output_freq_reduction,
  input  wire logic                  ramp_decel,
  input  wire logic                  ramp_accel,
  input  wire logic                  ramp_frozen,
  input  wire logic                  setpoint_ok,
  input  wire logic                  dc_reg_act,
  input  wire logic                  defaults_50hz,
  input  wire logic                  ride_through_act,
  input  wire logic                  flying_start_act,
  input  wire logic                  dc_brake_act,
  input  wire logic                  pwm_enabled,
  input  wire logic signed [15:0]    out_freq,
  input  wire logic        [15:0]    rated_motor_frequency,
  // Read port
  input  wire logic                  rd_req,
  input  wire logic [IDX_W-1:0]      rd_idx,
  input  wire logic                  wr_req,
  output logic [WORD_W-1:0]          rd_data_ff,
  output logic                       rd_ack_ff,
  output logic                       rd_err_ff,
  output logic                       wr_refused_ff,
  // Direct views
  output logic [WORD_W-1:0]          primary_drive_status,
  output logic [WORD_W-1:0]          secondary_drive_status,
  output logic [WORD_W-1:0]          scaled_output_speed
);
  import drive_status_pkg::*;

  // --------------------------------------------------------------
  // Word assembly
  // --------------------------------------------------------------
  logic [15:0] nxt_primary;
  logic [15:0] nxt_secondary;
  logic [15:0] primary_ff;
  logic [15:0] secondary_ff;
  logic [15:0] speed_word;
  logic        speed_done;
  logic        div_start_ff;

  // Unused positions stay zero by construction
  always_comb begin
    nxt_primary                 = STATUS_RST;
    nxt_primary[PB_RUN_CMD]     = run_cmd;
    nxt_primary[PB_FIRE_MODE]   = fire_mode_act;
    nxt_primary[PB_SECOND_RAMP] = second_ramp_sel;
    nxt_primary[PB_CONFIG]      = config_state;
    nxt_primary[PB_ALARM]       = alarm_act;
    nxt_primary[PB_RUNNING]     = motor_running;
    nxt_primary[PB_ENABLED]     = drive_enabled;
    nxt_primary[PB_FORWARD]     = dir_forward;
    nxt_primary[PB_JOG]         = jog_act;
    nxt_primary[PB_REMOTE]      = remote_mode;
    nxt_primary[PB_UNDERVOLT]   = undervoltage;
    nxt_primary[PB_FAULT]       = fault_act;
  end

  always_comb begin
    nxt_secondary                 = STATUS_RST;
    nxt_secondary[SB_DC_EXT]      = dc_ext_act;
    nxt_secondary[SB_ENERGY_SAVE] = energy_save_act;
    nxt_secondary[SB_FREQ_REDUCE] = output_freq_reduction;
    nxt_secondary[SB_DECEL]       = ramp_decel;
    nxt_secondary[SB_ACCEL]       = ramp_accel;
    nxt_secondary[SB_FROZEN]      = ramp_frozen;
    nxt_secondary[SB_SETPOINT_OK] = setpoint_ok;
    nxt_secondary[SB_DC_REG]      = dc_reg_act;
    nxt_secondary[SB_CFG_50HZ]    = defaults_50hz;
    nxt_secondary[SB_RIDE_THRU]   = ride_through_act;
    nxt_secondary[SB_FLYING]      = flying_start_act;
    nxt_secondary[SB_DC_BRAKE]    = dc_brake_act;
    nxt_secondary[SB_PWM_ON]      = pwm_enabled;
  end

  // --------------------------------------------------------------
  // Status registers
  // --------------------------------------------------------------
  // Refreshed every cycle; nothing else can load them
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      primary_ff   <= STATUS_RST;
      secondary_ff <= STATUS_RST;
    end else begin
      primary_ff   <= nxt_primary;
      secondary_ff <= nxt_secondary;
    end
  end

  assign primary_drive_status   = primary_ff;
  assign secondary_drive_status = secondary_ff;
  assign scaled_output_speed    = speed_word;

  // --------------------------------------------------------------
  // Speed scaling
  // --------------------------------------------------------------
  // Restart as soon as the divider returns; the word lags by ~31 cycles
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_start_ff <= 1'b1;
    end else begin
      div_start_ff <= speed_done;
    end
  end

  speed_scaler u_speed_scaler (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .start    (div_start_ff),
    .freq_in  (out_freq),
    .rated_in (rated_motor_frequency),
    .speed_ff (speed_word),
    .done_ff  (speed_done)
  );

  // --------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------
  // Unknown indices answer with zero data and an error pulse
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_ff <= STATUS_RST;
      rd_ack_ff  <= 1'b0;
      rd_err_ff  <= 1'b0;
    end else begin
      rd_ack_ff <= rd_req;
      rd_err_ff <= 1'b0;
      if (rd_req) begin
        case (rd_idx)
          IDX_PRIMARY:   rd_data_ff <= primary_ff;
          IDX_SPEED:     rd_data_ff <= speed_word;
          IDX_SECONDARY: rd_data_ff <= secondary_ff;
          default: begin
            rd_data_ff <= STATUS_RST;
            rd_err_ff  <= 1'b1;
          end
        endcase
      end
    end
  end

  // Writes never reach the words; only a refusal pulse
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_refused_ff <= 1'b0;
    end else begin
      wr_refused_ff <= wr_req;
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_read_known;
    rd_req && (rd_idx == IDX_PRIMARY);
  endsequence

  sequence s_ack_primary;
    rd_ack_ff && !rd_err_ff && (rd_data_ff == $past(primary_ff));
  endsequence

  // Inputs seen while reset was low never loaded, so skip the release edge
  sequence s_out_of_reset;
    $past(rst_b);
  endsequence

  sequence s_read_speed;
    rd_req && (rd_idx == IDX_SPEED);
  endsequence

  // Word contents
  a_reserved_zero: assert property (
    ((primary_ff & PRI_RSV_MASK) == 16'h0000) &&
    ((secondary_ff & SEC_RSV_MASK) == 16'h0000)
  ) else $error("reserved status bits not zero");

  a_run_fire_ramp: assert property (
    s_out_of_reset |-> (primary_ff[PB_RUN_CMD] == $past(run_cmd) &&
    primary_ff[PB_FIRE_MODE] == $past(fire_mode_act) &&
    primary_ff[PB_SECOND_RAMP] == $past(second_ramp_sel))
  ) else $error("run, override or ramp bit wrong");

  a_config_alarm: assert property (
    $rose(config_state) |=> primary_ff[PB_CONFIG] ##1
      (primary_ff[PB_ALARM] == $past(alarm_act))
  ) else $error("config or alarm bit wrong");

  a_run_enable_dir: assert property (
    (motor_running && drive_enabled && !dir_forward) |=>
      primary_ff[PB_RUNNING] && primary_ff[PB_ENABLED] && !primary_ff[PB_FORWARD]
  ) else $error("running, enabled or direction bit wrong");

  a_jog_remote_fault: assert property (
    s_out_of_reset |-> primary_ff[15:11] ==
      {$past(fault_act), 1'b0, $past(undervoltage), $past(remote_mode), $past(jog_act)}
  ) else $error("jog, remote, undervoltage or fault bit wrong");

  a_sec_low_bits: assert property (
    s_out_of_reset |->
    secondary_ff[9:2] == {$past(setpoint_ok), $past(ramp_frozen), $past(ramp_accel),
                          $past(ramp_decel), 1'b0, $past(output_freq_reduction),
                          $past(energy_save_act), $past(dc_ext_act)}
  ) else $error("secondary low flags wrong");

  a_sec_high_bits: assert property (
    s_out_of_reset |->
    secondary_ff[15:10] == {$past(pwm_enabled), $past(dc_brake_act),
                            $past(flying_start_act), $past(ride_through_act),
                            $past(defaults_50hz), $past(dc_reg_act)}
  ) else $error("secondary high flags wrong");

  // Read port answers
  a_read_primary: assert property (
    s_read_known |=> s_ack_primary
  ) else $error("primary read answer wrong");

  a_read_speed: assert property (
    s_read_speed |=>
      rd_ack_ff && !rd_err_ff && (rd_data_ff == $past(speed_word))
  ) else $error("speed read answer wrong");

  a_read_secondary: assert property (
    rd_req && (rd_idx == IDX_SECONDARY) |=>
      rd_ack_ff && !rd_err_ff && (rd_data_ff == $past(secondary_ff))
  ) else $error("secondary read answer wrong");

  a_read_unmapped: assert property (
    rd_req && rd_idx != IDX_PRIMARY && rd_idx != IDX_SPEED &&
    rd_idx != IDX_SECONDARY |=> rd_err_ff && rd_ack_ff && rd_data_ff == 16'h0000
  ) else $error("unmapped read not flagged");

  // An answer without a request would look like a second read
  a_ack_single: assert property (
    !rd_req |=> !rd_ack_ff && !rd_err_ff
  ) else $error("read answer without request");

  a_write_ignored: assert property (
    wr_req && $stable(nxt_primary) |=> wr_refused_ff && primary_ff == $past(nxt_primary)
  ) else $error("write disturbed status word");

  a_refuse_pulse: assert property (
    !wr_req |=> !wr_refused_ff
  ) else $error("refusal without write attempt");

  // Speed word; inputs are taken 31 samples before the result shows
  a_speed_rated: assert property (
    speed_done && $past(rated_motor_frequency, 31) != 16'h0000 &&
    $past(out_freq, 31) == $signed($past(rated_motor_frequency, 31)) &&
    $past(rated_motor_frequency, 31) < 16'h8000
    |-> speed_word == SPEED_RATED
  ) else $error("rated frequency not scaled to 8192");

  a_speed_zero_rated: assert property (
    speed_done && $past(rated_motor_frequency, 31) == 16'h0000 &&
    !$past(out_freq[15], 31)
    |-> speed_word == SPEED_POS_MAX
  ) else $error("zero rated frequency not clamped");

  a_speed_hold: assert property (
    !speed_done |-> $stable(speed_word)
  ) else $error("speed word moved between results");

  a_speed_period: assert property (
    $rose(div_start_ff) |-> ##[30:32] speed_done
  ) else $error("speed word not refreshed in time");

endmodule : drive_status_word_bank

//--- dv/drive_status_word_bank_tb.sv
// Purpose: Self-checking bench for the drive status word bank.
// Assumes: Status inputs are levels on ref_clk; reads answer one cycle later.
// Notes:   Speed checks poll a bounded window, as the divider period is ~32 cycles.
module drive_status_word_bank_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import drive_status_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic                     ref_clk;
  logic                     rst_b;
  logic                     rd_req;
  logic                     wr_req;
  logic        [11:0]       pin;
  logic        [12:0]       sin;
  logic signed [15:0]       out_freq;
  logic        [15:0]       rated;
  logic [IDX_W-1:0]         rd_idx;
  logic [WORD_W-1:0]        rd_data;
  logic [WORD_W-1:0]        pri;
  logic [WORD_W-1:0]        sec;
  logic [WORD_W-1:0]        spd;
  logic                     rd_ack;
  logic                     rd_err;
  logic                     wr_ref;
  int                       err_count;
  int                       cmp_count;

  drive_status_word_bank u_drive_status_word_bank (
    .ref_clk                (ref_clk),
    .rst_b                  (rst_b),
    .run_cmd                (pin[0]),
    .fire_mode_act          (pin[1]),
    .second_ramp_sel        (pin[2]),
    .config_state           (pin[3]),
    .alarm_act              (pin[4]),
    .motor_running          (pin[5]),
    .drive_enabled          (pin[6]),
    .dir_forward            (pin[7]),
    .jog_act                (pin[8]),
    .remote_mode            (pin[9]),
    .undervoltage           (pin[10]),
    .fault_act              (pin[11]),
    .dc_ext_act             (sin[0]),
    .energy_save_act        (sin[1]),
    .output_freq_reduction  (sin[2]),
    .ramp_decel             (sin[3]),
    .ramp_accel             (sin[4]),
    .ramp_frozen            (sin[5]),
    .setpoint_ok            (sin[6]),
    .dc_reg_act             (sin[7]),
    .defaults_50hz          (sin[8]),
    .ride_through_act       (sin[9]),
    .flying_start_act       (sin[10]),
    .dc_brake_act           (sin[11]),
    .pwm_enabled            (sin[12]),
    .out_freq               (out_freq),
    .rated_motor_frequency  (rated),
    .rd_req                 (rd_req),
    .rd_idx                 (rd_idx),
    .wr_req                 (wr_req),
    .rd_data_ff             (rd_data),
    .rd_ack_ff              (rd_ack),
    .rd_err_ff              (rd_err),
    .wr_refused_ff          (wr_ref),
    .primary_drive_status   (pri),
    .secondary_drive_status (sec),
    .scaled_output_speed    (spd)
  );

  // Free-running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Inputs move 1 ns after the edge, away from sampling
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic walk_pri(input int i, input int pos);
    pin = 12'h001 << i;
    tick();
    chk(pri, 16'h0001 << pos);
  endtask : walk_pri

  task automatic walk_sec(input int i, input int pos);
    sin = 13'h0001 << i;
    tick();
    chk(sec, 16'h0001 << pos);
  endtask : walk_sec

  // Read request held until the edge that takes it
  task automatic rd(input logic [9:0] idx, input logic [15:0] exp, input logic err);
    rd_req = 1'b1;
    rd_idx = idx;
    tick();
    chk({15'h0, rd_ack}, 16'h0001);
    chk({15'h0, rd_err}, {15'h0, err});
    chk(rd_data, exp);
  endtask : rd

  // Bounded poll; a stale word after 80 cycles is a mismatch
  task automatic speed_case(input logic signed [15:0] f, input logic [15:0] exp);
    out_freq = f;
    for (int n = 0; n < 80 && spd !== exp; n++) tick();
    chk(spd, exp);
    if (spd !== exp) summarize();
  endtask : speed_case

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_primary;
    walk_pri(0, 1);
    walk_pri(1, 2);
    walk_pri(2, 5);
    walk_pri(3, 6);
    walk_pri(4, 7);
    walk_pri(5, 8);
    walk_pri(6, 9);
    walk_pri(7, 10);
    walk_pri(8, 11);
    walk_pri(9, 12);
    walk_pri(10, 13);
    walk_pri(11, 15);
    pin = '1;
    tick();
    chk(pri, 16'hbfe6);
    pin = '0;
    tick();
    chk(pri, 16'h0000);
  endtask : test_primary

  task automatic test_secondary;
    walk_sec(0, 2);
    walk_sec(1, 3);
    walk_sec(2, 4);
    walk_sec(3, 6);
    walk_sec(4, 7);
    walk_sec(5, 8);
    walk_sec(6, 9);
    walk_sec(7, 10);
    walk_sec(8, 11);
    walk_sec(9, 12);
    walk_sec(10, 13);
    walk_sec(11, 14);
    walk_sec(12, 15);
    sin = '1;
    tick();
    chk(sec, 16'hffdc);
  endtask : test_secondary

  // Rated 500 units maps to 8192; boundaries and truncation
  task automatic test_speed;
    rated = 16'd500;
    speed_case(16'sd500, 16'h2000);
    speed_case(-16'sd250, 16'hf000);
    speed_case(16'sd1999, 16'h7fef);
    speed_case(16'sd2000, 16'h7fff);
    speed_case(-16'sd2000, 16'h8000);
    rated = 16'h0000;
    speed_case(16'sd5, 16'h7fff);
    speed_case(-16'sd5, 16'h8000);
    rated = 16'd500;
    speed_case(16'sd0, 16'h0000);
    speed_case(16'sd1, 16'h0010);
  endtask : test_speed

  // Back-to-back reads of every word plus two unmapped indices
  task automatic test_reads;
    pin = '1;
    tick();
    rd(10'h2a8, 16'hbfe6, 1'b0);
    rd(10'h2a9, 16'h0010, 1'b0);
    rd(10'h2b2, 16'hffdc, 1'b0);
    rd(10'h2aa, 16'h0000, 1'b1);
    rd(10'h000, 16'h0000, 1'b1);
    rd_req = 1'b0;
    tick();
    chk({15'h0, rd_ack}, 16'h0000);
    chk({15'h0, rd_err}, 16'h0000);
  endtask : test_reads

  task automatic test_write;
    wr_req = 1'b1;
    rd_idx = 10'h2a8;
    tick();
    wr_req = 1'b0;
    chk({15'h0, wr_ref}, 16'h0001);
    chk(pri, 16'hbfe6);
    chk(sec, 16'hffdc);
    tick();
    chk({15'h0, wr_ref}, 16'h0000);
  endtask : test_write

  // Mid-run reset clears every view, then words follow inputs again
  task automatic test_reset;
    rst_b = 1'b0;
    #2;
    chk(pri, 16'h0000);
    chk(sec, 16'h0000);
    chk(spd, 16'h0000);
    tick();
    rst_b = 1'b1;
    tick();
    chk(pri, 16'hbfe6);
    chk(spd, 16'h0000);
    speed_case(16'sd1, 16'h0010);
  endtask : test_reset

  // ----------------------------------------------------------------
  // Closing report
  // ----------------------------------------------------------------
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    err_count = 0;
    cmp_count = 0;
    rst_b     = 1'b0;
    rd_req    = 1'b0;
    wr_req    = 1'b0;
    rd_idx    = '0;
    pin       = '0;
    sin       = '0;
    out_freq  = '0;
    rated     = 16'd500;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(pri, 16'h0000);
    rst_b = 1'b1;
    tick();
    test_primary();
    test_secondary();
    test_speed();
    test_reads();
    test_write();
    test_reset();
    summarize();
  end

endmodule : drive_status_word_bank_tb
